// file: src/dtc_timer.sv
// Dual up/down timer with capture/reload register and APB slave
//
// The APB register port and the register addresses were decided locally.
`include "dtc_defines.svh"
`timescale 1ns/10ps
`default_nettype none
module dtc_timer
    import dtc_pkg::*;
#(
    parameter int WIDTH = 16                      // Timer width
) (
    input  wire logic        core_clk,            // System clock
    input  wire logic        arst_n,              // Async reset, active low
    input  wire logic        psel,                // APB select
    input  wire logic        penable,             // APB enable
    input  wire logic        pwrite,              // APB direction
    input  wire logic [11:0] paddr,               // APB byte address
    input  wire logic [31:0] pwdata,              // APB write data
    output logic      [31:0] prdata,              // APB read data
    output logic             pready,              // APB ready
    output logic             pslverr,             // APB error
    input  wire logic        auxCountPin,         // Aux external count pin
    input  wire logic        coreCountPin,        // Core external count pin
    input  wire logic        coreDirPin,          // Core external direction pin
    input  wire logic        captureInputPin,     // Capture trigger pin
    input  wire logic        firstModCountIn,     // Other module count input
    input  wire logic        firstModDirIn,       // Other module direction input
    output logic             toggleLatchPin,      // Toggle latch pin level
    output logic             toggleLatchPinOe_n,  // Pin enable, low drives
    output logic             coreOvfPulse         // Core overflow to compare unit
);

    localparam logic [WIDTH-1:0] MAXV = {WIDTH{1'b1}};

    logic [31:0]      auxCtl_ff, coreCtl_ff, capCtl_ff;
    logic [WIDTH-1:0] auxCnt_ff, coreCnt_ff, capture_reload_reg_ff;
    logic             toggle_ff, capFlag_ff;
    logic [4:0]       sync1_ff, sync2_ff, last_ff;
    logic [7:0]       preCnt_ff;
    logic             preTick_ff;
    dtc_cap_e         capState_ff;

    // Pin synchronisers; first stage read only by second stage
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            sync1_ff <= 5'h0;
            sync2_ff <= 5'h0;
            last_ff  <= 5'h0;
        end else begin
            sync1_ff <= {firstModDirIn, firstModCountIn, captureInputPin,
                         coreDirPin, coreCountPin};
            sync2_ff <= sync1_ff;
            last_ff  <= sync2_ff;
        end
    end

    wire logic [4:0] rise = sync2_ff & ~last_ff;
    wire logic [4:0] fall = ~sync2_ff & last_ff;
    logic auxPinSync1_ff, auxPinSync2_ff, auxPinLast_ff;

    // Aux count pin has its own pair of stages
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            auxPinSync1_ff <= 1'b0;
            auxPinSync2_ff <= 1'b0;
            auxPinLast_ff  <= 1'b0;
        end else begin
            auxPinSync1_ff <= auxCountPin;
            auxPinSync2_ff <= auxPinSync1_ff;
            auxPinLast_ff  <= auxPinSync2_ff;
        end
    end

    // Edge select: 01 rising, 10 falling, 11 both, 00 none
    function automatic logic edgeHit(input logic [1:0] sel, input logic r, input logic f);
        edgeHit = (sel[0] & r) | (sel[1] & f);
    endfunction : edgeHit

    // Base prescaler tick every DTC_MIN_STEP clocks; slower rates divide it further
    logic preBase_ff;
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            preBase_ff <= 1'b0;
            preCnt_ff  <= 8'h00;
        end else begin
            preBase_ff <= ~preBase_ff;
            if (preBase_ff) begin
                preCnt_ff <= preCnt_ff + 8'h01;
            end
        end
    end

    // Prescale n: tick when low n bits of divider are all ones
    function automatic logic preTick(input logic [2:0] n, input logic [7:0] c, input logic b);
        logic [7:0] m;
        m = 8'hFF >> (4'd8 - {1'b0, n});
        preTick = b & ((c & m) == m);
    endfunction : preTick

    logic toggleLast_ff;
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            toggleLast_ff <= 1'b0;
        end else begin
            toggleLast_ff <= toggle_ff;
        end
    end

    // Core timer step decision
    logic coreStep, coreDown, coreWrap;
    always_comb begin
        coreStep = 1'b0;
        case (coreCtl_ff[`DTC_TC_SRC_HI:`DTC_TC_SRC_LO])
            DTC_SRC_EXTPIN: coreStep = edgeHit(coreCtl_ff[`DTC_TC_EDGE_HI:`DTC_TC_EDGE_LO],
                                               rise[0], fall[0]);
            default:        coreStep = preTick(coreCtl_ff[`DTC_TC_PRE_HI:`DTC_TC_PRE_LO],
                                               preCnt_ff, preBase_ff);
        endcase
        coreStep = coreStep & coreCtl_ff[`DTC_TC_RUN];
        coreDown = coreCtl_ff[`DTC_TC_EXTDIR] ? sync2_ff[1]
                                              : coreCtl_ff[`DTC_TC_DOWN];
        coreWrap = coreStep & (coreDown ? (coreCnt_ff == '0) : (coreCnt_ff == MAXV));
    end

    // Aux timer step; no direction pin exists for it
    logic auxStep, auxDown;
    always_comb begin
        auxStep = 1'b0;
        case (auxCtl_ff[`DTC_TC_SRC_HI:`DTC_TC_SRC_LO])
            DTC_SRC_EXTPIN: auxStep = edgeHit(auxCtl_ff[`DTC_TC_EDGE_HI:`DTC_TC_EDGE_LO],
                                              auxPinSync2_ff & ~auxPinLast_ff,
                                              ~auxPinSync2_ff & auxPinLast_ff);
            DTC_SRC_TOGGLE: auxStep = edgeHit(auxCtl_ff[`DTC_TC_EDGE_HI:`DTC_TC_EDGE_LO],
                                              toggle_ff & ~toggleLast_ff,
                                              ~toggle_ff & toggleLast_ff);
            default:        auxStep = preTick(auxCtl_ff[`DTC_TC_PRE_HI:`DTC_TC_PRE_LO],
                                              preCnt_ff, preBase_ff);
        endcase
        auxStep = auxStep & auxCtl_ff[`DTC_TC_RUN];
        auxDown = auxCtl_ff[`DTC_TC_DOWN];
    end

    // Capture trigger source: 00 capture pin, 01 count in, 10 dir in, 11 either
    logic capTrig;
    always_comb begin
        case (capCtl_ff[`DTC_CC_TRIG_HI:`DTC_CC_TRIG_LO])
            2'b00:   capTrig = edgeHit(capCtl_ff[`DTC_CC_EDGE_HI:`DTC_CC_EDGE_LO],
                                       rise[2], fall[2]);
            2'b01:   capTrig = rise[3] | fall[3];
            2'b10:   capTrig = rise[4] | fall[4];
            default: capTrig = rise[3] | fall[3] | rise[4] | fall[4];
        endcase
        capTrig = capTrig & capCtl_ff[`DTC_CC_CAPEN];
    end

    // APB decode; zero wait states
    wire logic apbWr = psel & penable & pwrite;
    wire logic apbRd = psel & ~pwrite;
    wire logic known = (paddr == `DTC_OFF_AUXCTL) | (paddr == `DTC_OFF_CORECTL)
                     | (paddr == `DTC_OFF_AUXCNT) | (paddr == `DTC_OFF_CORECNT)
                     | (paddr == `DTC_OFF_CAPTURE_RELOAD_REG) | (paddr == `DTC_OFF_CAPCTL)
                     | (paddr == `DTC_OFF_STATUS);
    assign pready  = 1'b1;
    assign pslverr = psel & penable & ~known;

    // Control registers
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            auxCtl_ff  <= `DTC_CTL_RESET;
            coreCtl_ff <= `DTC_CTL_RESET;
            capCtl_ff  <= `DTC_CTL_RESET;
        end else if (apbWr) begin
            if (paddr == `DTC_OFF_AUXCTL)  auxCtl_ff  <= {21'h0, pwdata[10:0]};
            if (paddr == `DTC_OFF_CORECTL) coreCtl_ff <= {21'h0, pwdata[10:0]};
            if (paddr == `DTC_OFF_CAPCTL)  capCtl_ff  <= {25'h0, pwdata[6:0]};
        end
    end

    // Core timer with reload on wrap; software write has lowest priority
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            coreCnt_ff <= `DTC_CNT_RESET;
        end else if (coreWrap && capCtl_ff[`DTC_CC_RELEN]) begin
            coreCnt_ff <= capture_reload_reg_ff;
        end else if (coreStep) begin
            coreCnt_ff <= coreDown ? coreCnt_ff - 1'b1 : coreCnt_ff + 1'b1;
        end else if (apbWr && paddr == `DTC_OFF_CORECNT) begin
            coreCnt_ff <= pwdata[WIDTH-1:0];
        end
    end

    // Toggle latch and overflow pulse
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            toggle_ff    <= 1'b0;
            coreOvfPulse <= 1'b0;
        end else begin
            coreOvfPulse <= coreWrap;
            if (coreWrap) begin
                toggle_ff <= ~toggle_ff;
            end
        end
    end

    assign toggleLatchPin     = toggle_ff;
    assign toggleLatchPinOe_n = ~coreCtl_ff[`DTC_TC_PINOE];

    // Capture sequencing: capture first, then optional clear a cycle later
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            capState_ff <= DTC_IDLE;
        end else begin
            case (capState_ff)
                DTC_CAPTURE: capState_ff <= capTrig ? DTC_CAPTURE
                                          : (capCtl_ff[`DTC_CC_CLR] ? DTC_CLEAR : DTC_IDLE);
                DTC_CLEAR:   capState_ff <= capTrig ? DTC_CAPTURE : DTC_IDLE;
                default:     capState_ff <= capTrig ? DTC_CAPTURE : DTC_IDLE;
            endcase
        end
    end

    // Capture register, also software writable
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            capture_reload_reg_ff  <= `DTC_CNT_RESET;
            capFlag_ff <= 1'b0;
        end else begin
            if (capTrig) begin
                capture_reload_reg_ff <= auxCnt_ff;
            end else if (apbWr && paddr == `DTC_OFF_CAPTURE_RELOAD_REG) begin
                capture_reload_reg_ff <= pwdata[WIDTH-1:0];
            end
            // Set wins over clear by write of one
            if (capTrig) begin
                capFlag_ff <= 1'b1;
            end else if (apbWr && paddr == `DTC_OFF_STATUS && pwdata[0]) begin
                capFlag_ff <= 1'b0;
            end
        end
    end

    // Aux timer; clear follows the capture cycle
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            auxCnt_ff <= `DTC_CNT_RESET;
        end else if (capState_ff == DTC_CAPTURE && capCtl_ff[`DTC_CC_CLR]) begin
            auxCnt_ff <= '0;
        end else if (auxStep) begin
            auxCnt_ff <= auxDown ? auxCnt_ff - 1'b1 : auxCnt_ff + 1'b1;
        end else if (apbWr && paddr == `DTC_OFF_AUXCNT) begin
            auxCnt_ff <= pwdata[WIDTH-1:0];
        end
    end

    // Read data registered at setup
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            prdata <= 32'h0000_0000;
        end else if (apbRd && !penable) begin
            case (paddr)
                `DTC_OFF_AUXCTL:  prdata <= auxCtl_ff;
                `DTC_OFF_CORECTL: prdata <= coreCtl_ff;
                `DTC_OFF_AUXCNT:  prdata <= 32'(auxCnt_ff);
                `DTC_OFF_CORECNT: prdata <= 32'(coreCnt_ff);
                `DTC_OFF_CAPTURE_RELOAD_REG:  prdata <= 32'(capture_reload_reg_ff);
                `DTC_OFF_CAPCTL:  prdata <= capCtl_ff;
                `DTC_OFF_STATUS:  prdata <= {30'h0, toggle_ff, capFlag_ff};
                default:          prdata <= 32'h0000_0000;
            endcase
        end
    end

    // Toggle latch flips exactly on a wrap
    a_toggle_flip: assert property (@(posedge core_clk) disable iff (!arst_n)
        coreWrap |=> (toggle_ff != $past(toggle_ff)))
        else $error("toggle latch did not flip on wrap");
    a_toggle_hold: assert property (@(posedge core_clk) disable iff (!arst_n)
        !coreWrap |=> $stable(toggle_ff))
        else $error("toggle latch changed without wrap");
    a_reload_value: assert property (@(posedge core_clk) disable iff (!arst_n)
        (coreWrap && capCtl_ff[`DTC_CC_RELEN]) |=> coreCnt_ff == $past(capture_reload_reg_ff))
        else $error("core reload value wrong");
    a_capture_value: assert property (@(posedge core_clk) disable iff (!arst_n)
        capTrig |=> capture_reload_reg_ff == $past(auxCnt_ff))
        else $error("capture value wrong");
    a_clear_after: assert property (@(posedge core_clk) disable iff (!arst_n)
        (capTrig && capCtl_ff[`DTC_CC_CLR]) |=> ##1 auxCnt_ff == '0)
        else $error("aux not cleared after capture");
    a_step_spacing: assert property (@(posedge core_clk) disable iff (!arst_n)
        (coreStep && coreCtl_ff[`DTC_TC_SRC_HI:`DTC_TC_SRC_LO] == DTC_SRC_PRESCALE
         && $stable(coreCtl_ff)) |=> !coreStep)
        else $error("prescaled step faster than two clocks");
    a_ovf_pulse: assert property (@(posedge core_clk) disable iff (!arst_n)
        coreWrap |=> coreOvfPulse ##1 !coreOvfPulse || $past(coreWrap))
        else $error("overflow pulse missing");
    a_aux_dir_sw: assert property (@(posedge core_clk) disable iff (!arst_n)
        (auxStep && !auxDown && auxCnt_ff != MAXV && capState_ff != DTC_CAPTURE)
        |=> auxCnt_ff == $past(auxCnt_ff) + 1'b1)
        else $error("aux up count wrong");
    a_pin_drive: assert property (@(posedge core_clk) disable iff (!arst_n)
        $changed(toggleLatchPin) |-> $past(coreWrap))
        else $error("toggle pin moved without wrap");

    // Direction pin, capture sources and register hold; these catch broken decode paths
    a_flag_on_capture: assert property (@(posedge core_clk) disable iff (!arst_n)
        capTrig |=> capFlag_ff)
        else $error("capture flag not set");
    a_core_ext_down: assert property (@(posedge core_clk) disable iff (!arst_n)
        (coreStep && !coreWrap && coreCtl_ff[`DTC_TC_EXTDIR] && sync2_ff[1])
        |=> coreCnt_ff == $past(coreCnt_ff) - 1'b1)
        else $error("core ignored high direction pin");
    a_core_ext_up: assert property (@(posedge core_clk) disable iff (!arst_n)
        (coreStep && !coreWrap && coreCtl_ff[`DTC_TC_EXTDIR] && !sync2_ff[1])
        |=> coreCnt_ff == $past(coreCnt_ff) + 1'b1)
        else $error("core ignored low direction pin");
    a_ovf_cause: assert property (@(posedge core_clk) disable iff (!arst_n)
        coreOvfPulse |-> $past(coreWrap))
        else $error("overflow pulse without wrap");
    a_trig_count_in: assert property (@(posedge core_clk) disable iff (!arst_n)
        (capCtl_ff[`DTC_CC_CAPEN] && capCtl_ff[`DTC_CC_TRIG_HI:`DTC_CC_TRIG_LO] == 2'b01
         && sync2_ff[3] != last_ff[3]) |=> capture_reload_reg_ff == $past(auxCnt_ff))
        else $error("capture on count input missing");
    a_trig_dir_in: assert property (@(posedge core_clk) disable iff (!arst_n)
        (capCtl_ff[`DTC_CC_CAPEN] && capCtl_ff[`DTC_CC_TRIG_HI:`DTC_CC_TRIG_LO] == 2'b10
         && sync2_ff[4] != last_ff[4]) |=> capture_reload_reg_ff == $past(auxCnt_ff))
        else $error("capture on direction input missing");
    a_capture_hold: assert property (@(posedge core_clk) disable iff (!arst_n)
        (!capTrig && !(apbWr && paddr == `DTC_OFF_CAPTURE_RELOAD_REG)) |=> $stable(capture_reload_reg_ff))
        else $error("capture register changed without cause");

endmodule : dtc_timer
`default_nettype wire

// file: src/dtc_defines.svh
// Register offsets, field positions, reset values and timing counts of the dual timer
`ifndef DTC_DEFINES_SVH
`define DTC_DEFINES_SVH

`define DTC_OFF_AUXCTL      12'h000
`define DTC_OFF_CORECTL     12'h004
`define DTC_OFF_AUXCNT      12'h008
`define DTC_OFF_CORECNT     12'h00C
`define DTC_OFF_CAPTURE_RELOAD_REG      12'h010
`define DTC_OFF_CAPCTL      12'h014
`define DTC_OFF_STATUS      12'h018

// Timer control fields
`define DTC_TC_RUN          0
`define DTC_TC_SRC_LO       1
`define DTC_TC_SRC_HI       2
`define DTC_TC_DOWN         3
`define DTC_TC_EXTDIR       4
`define DTC_TC_PRE_LO       5
`define DTC_TC_PRE_HI       7
`define DTC_TC_EDGE_LO      8
`define DTC_TC_EDGE_HI      9
`define DTC_TC_PINOE        10

// Capture control fields
`define DTC_CC_CAPEN        0
`define DTC_CC_EDGE_LO      1
`define DTC_CC_EDGE_HI      2
`define DTC_CC_TRIG_LO      3
`define DTC_CC_TRIG_HI      4
`define DTC_CC_CLR          5
`define DTC_CC_RELEN        6

`define DTC_CTL_RESET       32'h0000_0000
`define DTC_CNT_RESET       16'h0000

// Finest count step in system clocks
`define DTC_MIN_STEP        2

`endif

// file: src/dtc_pkg.sv
// Types shared by the dual timer design
package dtc_pkg;
    typedef enum logic [1:0] {
        DTC_SRC_PRESCALE = 2'b00,
        DTC_SRC_EXTPIN   = 2'b01,
        DTC_SRC_TOGGLE   = 2'b10
    } dtc_src_e;
    typedef enum logic [2:0] {
        DTC_IDLE    = 3'b001,
        DTC_CAPTURE = 3'b010,
        DTC_CLEAR   = 3'b100
    } dtc_cap_e;
endpackage : dtc_pkg

// file: verification/dtc_pin_model.sv
// Pin-side model driving the external count, direction and capture inputs
`timescale 1ns/10ps
`default_nettype none
module dtc_pin_model (
    input  wire logic core_clk,         // System clock
    output logic      auxCountPin,      // Aux count pin
    output logic      coreCountPin,     // Core count pin
    output logic      coreDirPin,       // Core direction pin
    output logic      captureInputPin,  // Capture trigger pin
    output logic      firstModCountIn,  // Other module count input
    output logic      firstModDirIn     // Other module direction input
);
    // Idle levels; direction held high so a wrongly honoured aux pin would count down
    initial begin
        auxCountPin     = 1'b0;
        coreCountPin    = 1'b0;
        coreDirPin      = 1'b1;
        captureInputPin = 1'b0;
        firstModCountIn = 1'b0;
        firstModDirIn   = 1'b0;
    end

    // One transition, then the level is held 4 clocks so the sync sees it once
    task automatic flip(input int which);
        @(posedge core_clk);
        case (which)
            0: begin
                auxCountPin  <= ~auxCountPin;
                coreCountPin <= ~coreCountPin;
            end
            1: captureInputPin <= ~captureInputPin;
            2: firstModCountIn <= ~firstModCountIn;
            4: coreDirPin <= ~coreDirPin;
            default: firstModDirIn <= ~firstModDirIn;
        endcase
        repeat (3) @(posedge core_clk);
    endtask : flip
endmodule : dtc_pin_model
`default_nettype wire

// file: verification/test_dual_timer_capture_reload.sv
// Self-checking bench for the dual timer with capture/reload register
`include "dtc_defines.svh"
`timescale 1ns/10ps
`default_nettype none
`define CHK(nm, exp, got) begin totalChecks++; if ((got) !== (exp)) begin fails++; \
    $display("[ERR] %s exp %h got %h", nm, exp, got); end end
module test_dual_timer_capture_reload
    import dtc_pkg::*;
;
    logic        core_clk = 1'b0;
    logic        arst_n   = 1'b0;
    logic        psel     = 1'b0;
    logic        penable  = 1'b0;
    logic        pwrite   = 1'b0;
    logic [11:0] paddr    = 12'h000;
    logic [31:0] pwdata   = 32'h0000_0000;
    logic [31:0] prdata, rd;
    logic        pready, pslverr, err, dir, clr;
    logic        toggleLatchPin, toggleLatchPinOe_n, coreOvfPulse;
    wire logic   auxCountPin, coreCountPin, coreDirPin;
    wire logic   captureInputPin, firstModCountIn, firstModDirIn;
    logic [31:0] seed = 32'h0000_9A0D;
    logic [15:0] c0, step, start, capModel;
    int          fails = 0, totalChecks = 0, m, sumM;

    // Clock, 100 MHz
    always #5 core_clk = ~core_clk;

    dtc_timer i_dut (.core_clk(core_clk), .arst_n(arst_n), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .auxCountPin(auxCountPin), .coreCountPin(coreCountPin),
        .coreDirPin(coreDirPin), .captureInputPin(captureInputPin),
        .firstModCountIn(firstModCountIn), .firstModDirIn(firstModDirIn),
        .toggleLatchPin(toggleLatchPin), .toggleLatchPinOe_n(toggleLatchPinOe_n),
        .coreOvfPulse(coreOvfPulse));

    dtc_pin_model i_pins (.core_clk(core_clk), .auxCountPin(auxCountPin),
        .coreCountPin(coreCountPin), .coreDirPin(coreDirPin),
        .captureInputPin(captureInputPin), .firstModCountIn(firstModCountIn),
        .firstModDirIn(firstModDirIn));

    function automatic logic [31:0] xorshift();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction : xorshift

    // Setup, access, release; a leading edge keeps strobes from being set twice
    task automatic apbCycle(input logic [11:0] a, input logic w, input logic [31:0] d);
        @(posedge core_clk);
        psel    <= 1'b1;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        @(posedge core_clk);
        penable <= 1'b1;
        @(posedge core_clk);
        while (pready !== 1'b1) @(posedge core_clk);
        rd      = prdata;
        err     = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask : apbCycle

    task automatic apbWrite(input logic [11:0] a, input logic [31:0] d);
        apbCycle(a, 1'b1, d);
    endtask : apbWrite

    task automatic apbRead(input logic [11:0] a);
        apbCycle(a, 1'b0, 32'h0000_0000);
    endtask : apbRead

    // Bounded wait for the overflow pulse; a timeout is a mismatch
    task automatic waitPulse();
        int i;
        i = 0;
        do begin
            @(negedge core_clk);
            i++;
        end while (coreOvfPulse !== 1'b1 && i < 200);
        `CHK("ovf seen", 1'b1, coreOvfPulse)
    endtask : waitPulse

    task automatic finalReport();
        if (fails == 0 && totalChecks > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask : finalReport

    // Watchdog, well beyond the several hundred cycles the sequence needs
    initial begin
        repeat (20000) @(posedge core_clk);
        fails++;
        finalReport();
    end

    initial begin
        repeat (20) @(posedge core_clk);
        arst_n <= 1'b1;
        // Reset values and the one unmapped word
        for (int a = 0; a < 8; a++) begin
            apbRead(12'(a * 4));
            `CHK("reset value", 32'h0000_0000, rd)
            `CHK("slverr", a == 7, err)
        end
        // Prescaled stepping: reads 64 clocks apart see 64/(2*2^n) steps
        for (int n = 0; n < 4; n++) begin
            dir = 1'(xorshift());
            apbWrite(`DTC_OFF_CORECNT, 32'h0000_8000);
            apbWrite(`DTC_OFF_CORECTL, 32'(1 | (n << 5) | (dir << 3)));
            apbRead(`DTC_OFF_CORECNT);
            c0 = rd[15:0];
            repeat (61) @(posedge core_clk);
            apbRead(`DTC_OFF_CORECNT);
            step = 16'(32 >> n);
            `CHK("step delta", dir ? c0 - step : c0 + step, rd[15:0])
            `CHK("upper zero", 16'h0000, rd[31:16])
        end
        // Wraps both ways toggle the latch, drive the pin and clock aux
        apbWrite(`DTC_OFF_AUXCNT, 32'h0000_0000);
        apbWrite(`DTC_OFF_AUXCTL, 32'h0000_0305);
        for (int i = 0; i < 4; i++) begin
            apbWrite(`DTC_OFF_CORECTL, 32'h0000_0400);
            apbWrite(`DTC_OFF_CORECNT, i % 2 ? 32'h0000_0002 : 32'h0000_FFFD);
            apbWrite(`DTC_OFF_CORECTL, 32'(32'h0000_0401 | ((i % 2) << 3)));
            waitPulse();
            `CHK("toggle pin", 1'(1 - i % 2), toggleLatchPin)
            `CHK("pin enable", 1'b0, toggleLatchPinOe_n)
            @(negedge core_clk);
            `CHK("pulse width", 1'b0, coreOvfPulse)
        end
        apbWrite(`DTC_OFF_CORECTL, 32'h0000_0000);
        // Enable bit lands at the write edge; look once it has settled
        @(negedge core_clk);
        `CHK("pin off", 1'b1, toggleLatchPinOe_n)
        apbRead(`DTC_OFF_AUXCNT);
        `CHK("aux on latch", 32'h0000_0004, rd)
        apbRead(`DTC_OFF_STATUS);
        `CHK("latch status", 1'b0, rd[1])
        // Wrap with and without reload from the capture register
        for (int r = 0; r < 2; r++) begin
            apbWrite(`DTC_OFF_CAPTURE_RELOAD_REG, 32'h0000_1234);
            apbWrite(`DTC_OFF_CAPCTL, 32'(r << 6));
            apbWrite(`DTC_OFF_CORECNT, 32'h0000_FFFF);
            apbWrite(`DTC_OFF_CORECTL, 32'h0000_0061);
            waitPulse();
            apbWrite(`DTC_OFF_CORECTL, 32'h0000_0000);
            apbRead(`DTC_OFF_CORECNT);
            `CHK("reload", r ? 32'h0000_1234 : 32'h0000_0000, rd)
        end
        // Capture per trigger source; aux dir bit set but must stay up
        capModel = 16'h1234;
        sumM = 0;
        apbWrite(`DTC_OFF_CORECNT, 32'h0000_0000);
        apbWrite(`DTC_OFF_CORECTL, 32'h0000_0103);
        apbWrite(`DTC_OFF_AUXCTL, 32'h0000_0113);
        for (int t = 0; t < 4; t++) begin
            clr = 1'(xorshift());
            start = 16'(xorshift());
            m = 1 + int'(xorshift() % 6);
            sumM += m;
            apbWrite(`DTC_OFF_AUXCNT, 32'(start));
            apbWrite(`DTC_OFF_CAPCTL, 32'(3 | (t << 3) | (clr << 5)));
            for (int k = 0; k < 2 * m; k++) i_pins.flip(0);
            i_pins.flip(t == 0 ? 2 : 1);
            repeat (4) @(posedge core_clk);
            apbRead(`DTC_OFF_CAPTURE_RELOAD_REG);
            `CHK("no capture", capModel, rd[15:0])
            capModel = start + 16'(m);
            i_pins.flip(t == 0 ? 1 : (t == 1 ? 2 : 3));
            repeat (4) @(posedge core_clk);
            apbRead(`DTC_OFF_CAPTURE_RELOAD_REG);
            `CHK("capture", capModel, rd[15:0])
            apbRead(`DTC_OFF_AUXCNT);
            `CHK("aux after", clr ? 16'h0000 : capModel, rd[15:0])
            apbRead(`DTC_OFF_STATUS);
            `CHK("cap flag", 1'b1, rd[0])
            apbWrite(`DTC_OFF_STATUS, 32'h0000_0001);
            apbRead(`DTC_OFF_STATUS);
            `CHK("flag clear", 1'b0, rd[0])
        end
        apbRead(`DTC_OFF_CORECNT);
        `CHK("core pin count", 16'(sumM), rd[15:0])
        // Direction pin steers the core on falling edges: one step down, three up
        apbWrite(`DTC_OFF_CORECTL, 32'h0000_0213);
        for (int k = 0; k < 2; k++) i_pins.flip(0);
        i_pins.flip(4);
        for (int k = 0; k < 6; k++) i_pins.flip(0);
        apbRead(`DTC_OFF_CORECNT);
        `CHK("core ext dir", 16'(sumM + 2), rd[15:0])
        finalReport();
    end
endmodule : test_dual_timer_capture_reload
`default_nettype wire
